// ### serial_rx_pkg.sv
// package: register map, field positions and reset values for the serial receiver
// assumes a 32-bit ahb-lite register bus, one word per register
package serial_rx_pkg;
  localparam logic [7:0] RX_STATUS_CONTROL_OFS = 8'h00;
  localparam logic [7:0] RX_DATA_OFS = 8'h04;
  localparam logic [7:0] TX_STATUS_CONTROL_OFS = 8'h08;
  localparam logic [7:0] BAUD_CONTROL_OFS = 8'h0c;
  localparam logic [7:0] BAUD_DIV_LOW_OFS = 8'h10;
  localparam logic [7:0] BAUD_DIV_HIGH_OFS = 8'h14;
  localparam logic [7:0] RX_INT_ENABLE_OFS = 8'h18;
  // receive_status_control fields
  localparam int PORT_ENABLE_BIT = 7;
  localparam int NINE_BIT_SELECT_BIT = 6;
  localparam int CONT_RECEIVE_BIT = 4;
  localparam int ADDR_DETECT_BIT = 3;
  localparam int FRAMING_ERR_BIT = 2;
  localparam int OVERRUN_ERR_BIT = 1;
  localparam int RX_NINTH_BIT = 0;
  // transmit_status_control fields used by the receiver
  localparam int SYNC_BIT = 4;
  localparam int HIGH_SPEED_BIT = 2;
  // baud_control fields
  localparam int WIDE_DIVISOR_BIT = 3;
  localparam int RX_IDLE_BIT = 6;
  // reset values
  localparam logic [7:0] RX_CTL_RESET = 8'h00;
  localparam logic [7:0] TX_CTL_RESET = 8'h02;
  localparam logic [7:0] BAUD_CTL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  // oversampling
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
  localparam logic [3:0] FULL_BIT_TICKS = 4'hf;
  localparam int FIFO_DEPTH = 2;
endpackage

// ### serial_rx.sv
// serial_rx: asynchronous receive path with two-entry fifo, framing/overrun errors,
// nine-bit reception and address detection; registers on ahb-lite.
// assumes RX pin synchronous to CLK; single-word ahb-lite transfers.
// Behaviour
// - fifo keeps framing error per character
// - status read-only; data read advances fifo
// - port disable clears framing status
// - framing error raises no interrupt
// - keep receiving after framing error
// - third character on full fifo: overrun
// - overrun blocks loads, fifo still readable
// - clearing receive or port enable clears overrun
// - nine-bit mode; ninth bit readable
// - address mode keeps only ninth-bit-one characters
// - flag on transfer; interrupt when enabled
// - address characters report ninth bit one
// - sixteen-times oversampling, mid start, majority
// - zero at stop marks framing error
// - receive flag while enabled and unread
`timescale 1ns/10ps
module serial_rx #(
  parameter int FIFO_ENTRIES = serial_rx_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // serial line and receive event
  input wire logic RX_PIN,
  output logic RECEIVE_FLAG,
  output logic RECEIVE_IRQ
);
  import serial_rx_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } rx_state_e;

  // two-of-three vote over the last oversamples
  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // register select from a captured byte address
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // registers
  logic [7:0] rx_ctl_q;
  logic [7:0] tx_ctl_q;
  logic [7:0] baud_ctl_q;
  logic [7:0] div_low_q;
  logic [7:0] div_high_q;
  logic rx_int_enable_q;
  logic overrun_q;

  // ahb address phase capture
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;

  wire logic bus_take = HSEL & HREADY & HTRANS[1];
  wire logic wr_rx_ctl = wr_pend_q & reg_hit(addr_q, RX_STATUS_CONTROL_OFS);
  wire logic wr_tx_ctl = wr_pend_q & reg_hit(addr_q, TX_STATUS_CONTROL_OFS);
  wire logic wr_baud_ctl = wr_pend_q & reg_hit(addr_q, BAUD_CONTROL_OFS);
  wire logic wr_div_low = wr_pend_q & reg_hit(addr_q, BAUD_DIV_LOW_OFS);
  wire logic wr_div_high = wr_pend_q & reg_hit(addr_q, BAUD_DIV_HIGH_OFS);
  wire logic wr_int_en = wr_pend_q & reg_hit(addr_q, RX_INT_ENABLE_OFS);
  wire logic rd_data_now = rd_pend_q & reg_hit(addr_q, RX_DATA_OFS);
  wire logic port_on = rx_ctl_q[PORT_ENABLE_BIT];
  wire logic cont_rx_on = rx_ctl_q[CONT_RECEIVE_BIT];
  wire logic nine_bit_on = rx_ctl_q[NINE_BIT_SELECT_BIT];
  wire logic addr_detect_on = rx_ctl_q[ADDR_DETECT_BIT];
  wire logic async_on = port_on & ~tx_ctl_q[SYNC_BIT];
  wire logic rx_enabled = async_on & cont_rx_on;

  // baud tick at sixteen times bit rate
  wire logic wide_div = baud_ctl_q[WIDE_DIVISOR_BIT];
  wire logic high_speed = tx_ctl_q[HIGH_SPEED_BIT];
  wire logic [15:0] divisor = wide_div ? {div_high_q, div_low_q} : {8'h00, div_low_q};
  wire logic [1:0] pre_sel = {wide_div, high_speed};
  logic [17:0] tick_cnt_q;
  // tick period: divisor+1, twice or four times that
  wire logic [17:0] tick_top = (pre_sel == 2'b00) ? {divisor, 2'b11} :
                               (pre_sel == 2'b11) ? {2'b00, divisor} : {1'b0, divisor, 1'b1};
  wire logic os_tick = (tick_cnt_q == 18'h00000);

  always_ff @(posedge CLK) begin
    if (!RST_B || !rx_enabled || os_tick)
      tick_cnt_q <= rx_enabled ? tick_top : 18'h00000;
    else
      tick_cnt_q <= tick_cnt_q - 18'h00001;
  end

  // receiver state machine
  rx_state_e state_q;
  logic [3:0] tick_q;
  logic [3:0] bit_cnt_q;
  logic [8:0] shift_q;
  logic [2:0] samp_q;
  logic rx_prev_q;

  wire logic bit_done = os_tick & (tick_q == FULL_BIT_TICKS);
  wire logic bit_val = majority(samp_q);
  wire logic [3:0] data_bits = nine_bit_on ? 4'h9 : 4'h8;
  wire logic stop_done = (state_q == ST_STOP) & bit_done;
  wire logic [8:0] char_word = nine_bit_on ? shift_q : {1'b0, shift_q[8:1]};
  wire logic char_ninth = char_word[8];
  wire logic char_framing_error_flag = ~bit_val;
  wire logic keep_char = ~addr_detect_on | (nine_bit_on & char_ninth);

  // fifo storage: data, ninth bit and framing error per entry
  logic [9:0] fifo_mem_q [FIFO_ENTRIES];
  logic [$clog2(FIFO_ENTRIES)-1:0] rd_ptr_q;
  logic [$clog2(FIFO_ENTRIES)-1:0] wr_ptr_q;
  logic [$clog2(FIFO_ENTRIES):0] count_q;

  wire logic fifo_empty = (count_q == '0);
  wire logic fifo_full = (count_q == ($clog2(FIFO_ENTRIES)+1)'(FIFO_ENTRIES));
  wire logic pop = rd_data_now & ~fifo_empty;
  wire logic char_arrive = stop_done & keep_char & ~overrun_q;
  wire logic push = char_arrive & (~fifo_full | pop);
  wire logic overrun_set = char_arrive & fifo_full & ~pop;
  wire logic [9:0] top_entry = fifo_mem_q[rd_ptr_q];

  function automatic logic [$clog2(FIFO_ENTRIES)-1:0] ptr_inc(input logic [$clog2(FIFO_ENTRIES)-1:0] p);
    ptr_inc = (p == ($clog2(FIFO_ENTRIES))'(FIFO_ENTRIES - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge CLK) begin
    if (!RST_B || !port_on) begin
      state_q <= ST_IDLE;
      tick_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= 9'h000;
      samp_q <= 3'h7;
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= RX_PIN;
      if (os_tick)
        samp_q <= {samp_q[1:0], RX_PIN};
      case (state_q)
        ST_IDLE: begin
          tick_q <= 4'h0;
          if (rx_enabled && rx_prev_q && !RX_PIN)
            state_q <= ST_START;
        end
        ST_START: begin
          if (os_tick)
            tick_q <= tick_q + 4'h1;
          if (os_tick && tick_q == HALF_BIT_TICKS) begin
            tick_q <= 4'h0;
            bit_cnt_q <= 4'h0;
            state_q <= RX_PIN ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (os_tick)
            tick_q <= tick_q + 4'h1;
          if (bit_done) begin
            shift_q <= {bit_val, shift_q[8:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == data_bits - 4'h1)
              state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (os_tick)
            tick_q <= tick_q + 4'h1;
          if (bit_done)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B || !port_on) begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        fifo_mem_q[wr_ptr_q] <= {char_framing_error_flag, char_word};
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      end
      if (pop)
        rd_ptr_q <= ptr_inc(rd_ptr_q);
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

  // overrun: an enable clear wins over a same-cycle set; set sticks while enables stay on
  always_ff @(posedge CLK) begin
    if (!RST_B || !port_on || !cont_rx_on)
      overrun_q <= 1'b0;
    else if (overrun_set)
      overrun_q <= 1'b1;
  end

  // bus phase capture
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= bus_take & HWRITE;
      rd_pend_q <= bus_take & ~HWRITE;
      if (bus_take)
        addr_q <= HADDR[7:0];
    end
  end

  // receive control: status bits and bit 5 are not stored
  always_ff @(posedge CLK) begin
    if (!RST_B)
      rx_ctl_q <= RX_CTL_RESET;
    else if (wr_rx_ctl)
      rx_ctl_q <= HWDATA[7:0] & 8'hd8;
  end

  // transmit control: only sync and speed select matter here
  always_ff @(posedge CLK) begin
    if (!RST_B)
      tx_ctl_q <= TX_CTL_RESET;
    else if (wr_tx_ctl)
      tx_ctl_q <= HWDATA[7:0] & 8'hfd;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B)
      baud_ctl_q <= BAUD_CTL_RESET;
    else if (wr_baud_ctl)
      baud_ctl_q <= HWDATA[7:0] & 8'h0b;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B)
      div_low_q <= DIV_RESET;
    else if (wr_div_low)
      div_low_q <= HWDATA[7:0];
  end

  always_ff @(posedge CLK) begin
    if (!RST_B)
      div_high_q <= DIV_RESET;
    else if (wr_div_high)
      div_high_q <= HWDATA[7:0];
  end

  always_ff @(posedge CLK) begin
    if (!RST_B)
      rx_int_enable_q <= 1'b0;
    else if (wr_int_en)
      rx_int_enable_q <= HWDATA[0];
  end

  // read data
  wire logic show_top = port_on & ~fifo_empty;
  // overrun reads clear as soon as an enable drops
  wire logic overrun_rd = overrun_q & port_on & cont_rx_on;
  wire logic [7:0] rx_ctl_rd = {rx_ctl_q[7:3], show_top & top_entry[9], overrun_rd,
                                show_top & top_entry[8]};
  wire logic [7:0] baud_rd = baud_ctl_q | {1'b0, state_q == ST_IDLE, 6'h00};
  wire logic [7:0] rd_mux = reg_hit(addr_q, RX_STATUS_CONTROL_OFS) ? rx_ctl_rd :
                            reg_hit(addr_q, RX_DATA_OFS) ? top_entry[7:0] :
                            reg_hit(addr_q, TX_STATUS_CONTROL_OFS) ? (tx_ctl_q | TX_CTL_RESET) :
                            reg_hit(addr_q, BAUD_CONTROL_OFS) ? baud_rd :
                            reg_hit(addr_q, BAUD_DIV_LOW_OFS) ? div_low_q :
                            reg_hit(addr_q, BAUD_DIV_HIGH_OFS) ? div_high_q :
                            reg_hit(addr_q, RX_INT_ENABLE_OFS) ? {7'h00, rx_int_enable_q} : 8'h00;
  assign HRDATA = rd_pend_q ? {24'h000000, rd_mux} : 32'h00000000;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  assign RECEIVE_FLAG = rx_enabled & ~fifo_empty;
  assign RECEIVE_IRQ = RECEIVE_FLAG & rx_int_enable_q;
endmodule

// ### serial_rx_props.sv
// checker: bus and receive-flag properties
// assumes bound onto serial_rx ports
`timescale 1ns/10ps
module serial_rx_props
  import serial_rx_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // line and flags
  input wire logic RX_PIN,
  input wire logic RECEIVE_FLAG,
  input wire logic RECEIVE_IRQ
);
  logic rd_q;
  logic wr_q;
  logic [7:0] a_q;
  wire take = HSEL & HREADY & HTRANS[1];
  wire st = rd_q & (a_q == RX_STATUS_CONTROL_OFS);
  wire pop = rd_q & (a_q == RX_DATA_OFS) | wr_q;
  always_ff @(posedge CLK) begin
    rd_q <= RST_B & take & !HWRITE;
    wr_q <= RST_B & take & HWRITE;
    a_q <= HADDR[7:0];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  chk_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus stall");
  chk_idle_zero: assert property (!rd_q |-> HRDATA == 32'h0) else $error("stray data");
  chk_irq_flag: assert property (RECEIVE_IRQ |-> RECEIVE_FLAG) else $error("lone irq");
  chk_flag_fall: assert property ($fell(RECEIVE_FLAG) |-> pop || $past(pop)) else $error("flag fell");
  chk_reset_quiet: assert property ($rose(RST_B) |-> !RECEIVE_FLAG [*4]) else $error("early flag");
  chk_off_status: assert property (st && !HRDATA[PORT_ENABLE_BIT] |-> HRDATA[2:0] == 3'h0)
    else $error("status while off");
  chk_overrun_clear: assert property (st && !HRDATA[CONT_RECEIVE_BIT] |-> !HRDATA[OVERRUN_ERR_BIT])
    else $error("overrun held");
  chk_addr_ninth: assert property (st && HRDATA[ADDR_DETECT_BIT] && RECEIVE_FLAG |-> HRDATA[RX_NINTH_BIT])
    else $error("ninth bit low");
endmodule
bind serial_rx serial_rx_props chk_u (.CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
  .HREADY, .HRDATA, .HREADYOUT, .HRESP, .RX_PIN, .RECEIVE_FLAG, .RECEIVE_IRQ);

// ### serial_line_model.sv
// model: remote transmitter on the receive line
// assumes 16 clocks per bit, line idles high
`timescale 1ns/10ps
module serial_line_model (
  // clock
  input wire logic CLK,
  // line
  output logic RX_PIN
);
  initial RX_PIN = 1'b1;
  // start, data lsb first, stop, then idle gap
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int gap);
    for (int i = 0; i < nb + 2; i++) begin
      RX_PIN <= (i == 0) ? 1'b0 : (i > nb) ? stop : d[i-1];
      repeat (16) @(posedge CLK);
    end
    RX_PIN <= 1'b1;
    repeat (16 + gap) @(posedge CLK);
  endtask
endmodule

// ### serial_rx_bench.sv
// bench: serial_rx via ahb-lite and a line model
// assumes zero-wait slave, 16 clocks per bit
`timescale 1ns/10ps
module serial_rx_bench;
  import serial_rx_pkg::*;
  localparam logic [7:0] ST = RX_STATUS_CONTROL_OFS;
  localparam logic [7:0] DT = RX_DATA_OFS;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic rd_dp = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, RX_PIN, RECEIVE_FLAG, RECEIVE_IRQ;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h14a1;
  logic [7:0] v [4];
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #4 CLK = ~CLK;
  serial_rx dut_u (.CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .RX_PIN, .RECEIVE_FLAG, .RECEIVE_IRQ);
  serial_line_model tx_u (.CLK, .RX_PIN);
  task automatic test_done();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_dp <= !wr;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    bus(1'b0, a, 32'h0);
  endtask
  // read checker and hang guard
  always @(posedge CLK) begin
    if (rd_dp) chk(HRDATA, exp_q.pop_front());
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      v[i] = seed[7:0];
    end
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd(ST, {24'h0, RX_CTL_RESET});
    rd(8'h40, 32'h0);
    bus(1'b1, TX_STATUS_CONTROL_OFS, 32'h4);
    bus(1'b1, BAUD_CONTROL_OFS, 32'h8);
    bus(1'b1, RX_INT_ENABLE_OFS, 32'h1);
    bus(1'b1, ST, 32'h90);
    $display("test setup done");
    tx_u.send({1'b0, v[0]}, 8, 1'b1, 0);
    tx_u.send({1'b0, v[1]}, 8, 1'b0, 0);
    chk({30'h0, RECEIVE_IRQ, RECEIVE_FLAG}, 32'h3);
    tx_u.send({1'b0, v[2]}, 8, 1'b1, 40);
    rd(ST, 32'h92);
    rd(DT, {24'h0, v[0]});
    rd(ST, 32'h96);
    rd(DT, {24'h0, v[1]});
    tx_u.send({1'b0, v[3]}, 8, 1'b1, 0);
    rd(ST, 32'h92);
    chk({31'h0, RECEIVE_FLAG}, 32'h0);
    bus(1'b1, ST, 32'h80);
    rd(ST, 32'h80);
    bus(1'b1, ST, 32'h90);
    $display("test overrun done");
    tx_u.send({1'b0, v[2]}, 8, 1'b0, 0);
    bus(1'b1, ST, 32'h80);
    rd(ST, 32'h84);
    bus(1'b1, ST, 32'h00);
    rd(ST, 32'h00);
    bus(1'b1, ST, 32'hd8);
    rd(ST, 32'hd8);
    $display("test disable done");
    tx_u.send({1'b0, v[0]}, 9, 1'b1, 0);
    tx_u.send({1'b1, v[1]}, 9, 1'b1, 0);
    rd(ST, 32'hd9);
    rd(DT, {24'h0, v[1]});
    rd(ST, 32'hd8);
    bus(1'b1, ST, 32'hd0);
    tx_u.send({1'b0, v[3]}, 9, 1'b1, 0);
    rd(ST, 32'hd0);
    rd(DT, {24'h0, v[3]});
    $display("test nine bit done");
    test_done();
  end
endmodule
